//--- cfu_defines.svh
/*
  Constants for the condition flag update block: flag bit positions,
  result widths, sign positions, flag reset value and cycle figures.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CFU_DEFINES_SVH
`define CFU_DEFINES_SVH

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define CFU_BIT_C        0
`define CFU_BIT_V        1
`define CFU_BIT_Z        2
`define CFU_BIT_N        3
`define CFU_BIT_U        4
`define CFU_BIT_E        5
`define CFU_BIT_L        6
`define CFU_BIT_S        7
`define CFU_NUM_FLAGS    8

// ----------------------------------------
// Result widths, sign positions and flag reset value
// ----------------------------------------
`define CFU_ACC_W        36
`define CFU_SIGN_LONG    35
`define CFU_SIGN_SHORT   31
`define CFU_FLAGS_RST    8'h00

// ----------------------------------------
// Cycle count figures
// ----------------------------------------
`define CFU_CYC_W        4
`define CFU_EXTRA_CYC    4'h1

`endif

//--- cfu_pkg.sv
/*
  Types for the condition flag update block.
  Assumes cfu_defines.svh is on the include path.
*/
`include "cfu_defines.svh"

package cfu_pkg;

  // ----------------------------------------
  // Per-flag action selector
  // ----------------------------------------
  typedef enum logic [2:0] {
    CFU_ACT_KEEP  = 3'h0,
    CFU_ACT_STD   = 3'h1,
    CFU_ACT_CLR   = 3'h2,
    CFU_ACT_SET   = 3'h3,
    CFU_ACT_SPEC  = 3'h4
  } cfu_act_e;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CFU_ST_IDLE = 2'b01,
    CFU_ST_EXEC = 2'b10
  } cfu_state_e;

  // ----------------------------------------
  // One operation issued to the block
  // ----------------------------------------
  typedef struct packed {
    logic [`CFU_ACC_W-1:0]       result;
    logic                        narrow;
    logic                        carry;
    logic                        ovf;
    logic                        limited;
    logic [`CFU_NUM_FLAGS-1:0]   spec_val;
    logic [`CFU_CYC_W-1:0]       base_cyc;
    logic                        pre_upd;
    logic                        long_abs;
    logic                        long_imm;
  } cfu_op_s;

  typedef cfu_act_e [`CFU_NUM_FLAGS-1:0] cfu_act_t;

endpackage

//--- cfu_flag_update.sv
/*
  Condition flag update and instruction timing for the arithmetic unit.
  Assumes the decoder issues one operation with a one-cycle start pulse;
  op and actions are captured at issue and may change before done, and
  all inputs are synchronous to mclk_in.
*/
// Notes on behaviour
// - Negative flag copies sign bit: bit 35, or bit 31 for narrow results.
// - Zero flag set when every result bit is zero, else cleared.
// - Overflow flag set on arithmetic overflow of the result, else cleared.
// - Carry flag set on addition carry or subtraction borrow, else cleared.
// - Limit flag set on overflow or saturation on transfer; sticky.
// - Scaling flag set when data growth is detected; sticky.
// - Extension flag set when the extension part holds significant bits.
// - Unnormalized flag set when the result is not normalized.
// - Standard action updates a flag from its general definition.
// - Unaffected action keeps the previous flag value.
// - Forced clear action writes zero whatever the result.
// - Forced set action writes one whatever the result.
// - Special action takes the instruction-specific value instead.
// - Add one cycle each for pre-update, long absolute, long immediate.
`timescale 1ns/1ps
`include "cfu_defines.svh"

module cfu_flag_update
  import cfu_pkg::*;
#(
  parameter int ACC_W = `CFU_ACC_W
) (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       nrst_in,
  // Operation issue
  input  wire logic                       start_in,
  input  wire cfu_op_s                    op_in,
  input  wire cfu_act_t                   act_in,
  // Flag state and status
  output logic [`CFU_NUM_FLAGS-1:0]       condition_flags_register_out,
  output logic                            busy_out,
  output logic                            done_out,
  output logic [`CFU_CYC_W-1:0]           total_cyc_out
);

  // ----------------------------------------
  // Standard flag definitions
  // ----------------------------------------
  logic [`CFU_NUM_FLAGS-1:0]  std_val;
  logic [`CFU_NUM_FLAGS-1:0]  new_flags;
  logic [`CFU_NUM_FLAGS-1:0]  flags_r;
  logic [`CFU_NUM_FLAGS-1:0]  flags_nxt;
  logic [`CFU_CYC_W-1:0]      total_cyc;
  logic [`CFU_CYC_W-1:0]      cnt_r;
  logic [`CFU_CYC_W-1:0]      cnt_nxt;
  logic [`CFU_CYC_W-1:0]      tot_r;
  logic                       busy_r;
  logic                       done_r;
  logic                       done_nxt;
  cfu_state_e                 state_r;
  cfu_state_e                 state_nxt;
  cfu_op_s                    op_r;
  cfu_act_t                   act_r;

  wire [ACC_W-1:0] res        = op_r.result;
  wire             sign_bit   = op_r.narrow ? res[`CFU_SIGN_SHORT]
                                            : res[`CFU_SIGN_LONG];
  wire             res_zero   = (res == '0);
  // Extension bits 35..31 all equal means pure sign extension
  wire             ext_used   = !((&res[35:31]) || !(|res[35:31]));
  // Unnormalized when the two top fraction bits agree and extension unused
  wire             unnorm     = !ext_used && (res[31] == res[30]);
  // Growth: the bits next to the binary point agree no longer
  wire             growth     = (res[31] != res[30]);

  assign std_val[`CFU_BIT_C] = op_r.carry;
  assign std_val[`CFU_BIT_V] = op_r.ovf;
  assign std_val[`CFU_BIT_Z] = res_zero;
  assign std_val[`CFU_BIT_N] = sign_bit;
  assign std_val[`CFU_BIT_U] = unnorm;
  assign std_val[`CFU_BIT_E] = ext_used;
  // Limit and scaling only ever set; software clears them elsewhere
  assign std_val[`CFU_BIT_L] = flags_r[`CFU_BIT_L] | op_r.ovf | op_r.limited;
  assign std_val[`CFU_BIT_S] = flags_r[`CFU_BIT_S] | growth;

  // ----------------------------------------
  // Per-flag action selection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CFU_NUM_FLAGS; gi++) begin : g_flag
      always_comb begin
        case (act_r[gi])
          CFU_ACT_STD:  new_flags[gi] = std_val[gi];
          CFU_ACT_CLR:  new_flags[gi] = 1'b0;
          CFU_ACT_SET:  new_flags[gi] = 1'b1;
          CFU_ACT_SPEC: new_flags[gi] = op_r.spec_val[gi];
          default:      new_flags[gi] = flags_r[gi];
        endcase
      end
    end
  endgenerate

  // ----------------------------------------
  // Cycle count
  // ----------------------------------------
  assign total_cyc = op_in.base_cyc
                   + (op_in.pre_upd  ? `CFU_EXTRA_CYC : 4'h0)
                   + (op_in.long_abs ? `CFU_EXTRA_CYC : 4'h0)
                   + (op_in.long_imm ? `CFU_EXTRA_CYC : 4'h0);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Flags land only on the last execute cycle so a follower sees one set
  wire last_cyc = (cnt_r <= 4'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    flags_nxt = flags_r;
    done_nxt  = 1'b0;
    case (state_r)
      CFU_ST_IDLE: begin
        if (start_in) begin
          state_nxt = CFU_ST_EXEC;
          cnt_nxt   = total_cyc;
        end
      end
      CFU_ST_EXEC: begin
        if (last_cyc) begin
          state_nxt = CFU_ST_IDLE;
          flags_nxt = new_flags;
          done_nxt  = 1'b1;
          cnt_nxt   = 4'h0;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: state_nxt = CFU_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_r <= CFU_ST_IDLE;
      cnt_r   <= 4'h0;
      flags_r <= `CFU_FLAGS_RST;
      done_r  <= 1'b0;
      busy_r  <= 1'b0;
      tot_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      flags_r <= flags_nxt;
      done_r  <= done_nxt;
      busy_r  <= (state_nxt == CFU_ST_EXEC);
      if (state_r == CFU_ST_IDLE && start_in) begin
        tot_r <= total_cyc;
      end
    end
  end

  // Operands captured at issue; no reset needed for pure data
  always_ff @(posedge mclk_in) begin
    if (state_r == CFU_ST_IDLE && start_in) begin
      op_r  <= op_in;
      act_r <= act_in;
    end
  end

  assign condition_flags_register_out = flags_r;
  assign busy_out                     = busy_r;
  assign done_out                     = done_r;
  assign total_cyc_out                = tot_r;

endmodule // cfu_flag_update

//--- cfu_flag_update_chk.sv
/* Port checker for cfu_flag_update.
   Assumes it is bound to each instance. */
`timescale 1ns/1ps
`include "cfu_defines.svh"
module cfu_chk
  import cfu_pkg::*;
#(parameter int ACC_W = `CFU_ACC_W) (
  // Clock, reset, issue
  input wire logic                     mclk_in,
  input wire logic                     nrst_in,
  input wire logic                     start_in,
  input wire cfu_op_s                  op_in,
  input wire cfu_act_t                 act_in,
  // Status
  input wire logic [`CFU_NUM_FLAGS-1:0] condition_flags_register_out,
  input wire logic                     busy_out,
  input wire logic                     done_out,
  input wire logic [`CFU_CYC_W-1:0]    total_cyc_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_take;
    start_in && !busy_out;
  endsequence
  // Shadow of the issued op, since op_in may move after issue
  cfu_op_s    op_r;
  cfu_act_t   act_r;
  logic [3:0] cnt_r;
  always_ff @(posedge mclk_in) begin
    if (start_in && !busy_out) begin
      op_r <= op_in;
      act_r <= act_in;
      cnt_r <= 4'h0;
    end else if (busy_out) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  wire logic [7:0] fl = condition_flags_register_out;
  a_rst_idle: assert property (disable iff (1'b0) !nrst_in |=> fl == 8'h00 && !busy_out && !done_out)
    else $error("flags or status not idle after reset");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_take_busy: assert property (s_take |=> busy_out &&
    total_cyc_out == op_r.base_cyc + op_r.pre_upd + op_r.long_abs + op_r.long_imm)
    else $error("wrong total or no busy after issue");
  a_busy_len: assert property (done_out |-> cnt_r == (total_cyc_out > 4'h1 ? total_cyc_out : 4'h1))
    else $error("busy length differs from total");
  a_done_bound: assert property (s_take |-> ##[2:16] done_out)
    else $error("done missing");
  a_neg_std: assert property (done_out && act_r[3] == CFU_ACT_STD |->
    fl[3] == (op_r.narrow ? op_r.result[31] : op_r.result[35]))
    else $error("negative flag wrong");
  a_zero_std: assert property (done_out && act_r[2] == CFU_ACT_STD |-> fl[2] == (op_r.result == '0))
    else $error("zero flag wrong");
  a_keep_flag: assert property (done_out && act_r[1] == CFU_ACT_KEEP |-> $stable(fl[1]))
    else $error("kept flag changed");
  a_clr_flag: assert property (done_out && act_r[0] == CFU_ACT_CLR |-> !fl[0])
    else $error("cleared flag high");
  a_set_flag: assert property (done_out && act_r[0] == CFU_ACT_SET |-> fl[0])
    else $error("set flag low");
  a_flags_hold: assert property (!done_out && $past(nrst_in) |-> $stable(fl))
    else $error("flags moved without done");
endmodule // cfu_chk
bind cfu_flag_update cfu_chk #(.ACC_W(ACC_W)) u_chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .start_in(start_in), .op_in(op_in), .act_in(act_in), .busy_out(busy_out), .done_out(done_out),
  .condition_flags_register_out(condition_flags_register_out), .total_cyc_out(total_cyc_out));

//--- cfu_tb.sv
/* Testbench for cfu_flag_update.
   Assumes the bound checker is compiled first. */
`timescale 1ns/1ps
`include "cfu_defines.svh"
module testbench
  import cfu_pkg::*;
;
  logic       mclk_in = 0, nrst_in = 0, start_in = 0, busy, done;
  cfu_op_s    op_in = '0;
  cfu_act_t   act_in = '{default: CFU_ACT_KEEP};
  logic [7:0] flags, ef = 8'h00;
  logic [3:0] total;
  int         n_mismatch = 0, checked = 0, cyc = 0;
  cfu_flag_update dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .start_in(start_in), .op_in(op_in),
    .act_in(act_in), .condition_flags_register_out(flags), .busy_out(busy), .done_out(done),
    .total_cyc_out(total));
  initial forever #2.5 mclk_in = ~mclk_in;
  // Ceiling well above the roughly fifty cycles needed
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] xf(input logic [7:0] p, input cfu_op_s o, input cfu_act_t a);
    logic [7:0] s;
    logic [4:0] x;
    x = o.result[35:31];
    s[0] = o.carry;
    s[1] = o.ovf;
    s[2] = o.result == '0;
    s[3] = o.narrow ? o.result[31] : o.result[35];
    s[5] = !(x == 5'h00 || x == 5'h1F);
    s[4] = !s[5] && o.result[31] == o.result[30];
    s[6] = p[6] | o.ovf | o.limited;
    s[7] = p[7] | (o.result[31] ^ o.result[30]);
    for (int i = 0; i < 8; i++) begin
      case (a[i])
        CFU_ACT_STD: xf[i] = s[i];
        CFU_ACT_CLR: xf[i] = 1'b0;
        CFU_ACT_SET: xf[i] = 1'b1;
        CFU_ACT_SPEC: xf[i] = o.spec_val[i];
        default: xf[i] = p[i];
      endcase
    end
  endfunction
  // Issue one op; rf retries start while busy, which must be ignored
  task run(input cfu_op_s o, input cfu_act_t a, input bit rf);
    int n;
    logic [3:0] t;
    t = o.base_cyc + o.pre_upd + o.long_abs + o.long_imm;
    ef = xf(ef, o, a);
    op_in = o;
    act_in = a;
    start_in = 1;
    @(negedge mclk_in);
    start_in = rf;
    op_in = cfu_op_s'(~o);
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk_in);
      start_in = 0;
      n++;
    end
    check("cycles", n, (t < 2 ? 1 : t) + 1);
    check("total", total, t);
    check("flags", flags, ef);
    check("busy", busy, 0);
  endtask
  task t_reset();
    check("rst", {flags, busy, done, total}, 0);
  endtask
  task automatic t_std();
    cfu_op_s o = '0;
    o.result = 36'h8_0000_0000;
    o.carry = 1;
    o.ovf = 1;
    o.base_cyc = 4'h1;
    run(o, '{default: CFU_ACT_STD}, 0);
  endtask
  task automatic t_narrow();
    cfu_op_s o = '0;
    o.narrow = 1;
    run(o, '{default: CFU_ACT_STD}, 1);
    o.result = 36'h0_8000_0000;
    run(o, '{default: CFU_ACT_STD}, 0);
  endtask
  task automatic t_modes();
    cfu_op_s o = '0;
    cfu_act_t a;
    o.result = 36'hF_4000_1234;
    o.spec_val = 8'hA5;
    {o.pre_upd, o.long_abs, o.long_imm} = 3'h7;
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 8; i++) a[i] = cfu_act_e'((i + k) % 5);
      o.base_cyc = 4'hB + 4'(k);
      o.limited = k[0];
      run(o, a, k[0]);
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk_in);
    nrst_in = 1;
    t_reset();
    t_std();
    t_narrow();
    t_modes();
    finish_test();
  end
endmodule // testbench
